/* File: core/mivc_arbiter.sv */
`timescale 1ns/10ps
`default_nettype none
module mivc_arbiter (
	input  wire logic [14:0] request,
	input  wire logic [14:0] level,
	output logic             found,
	output logic [3:0]       winner,
	output logic             winner_high
);
	logic [14:0] high_req;

	// ************************************************************
	// Lowest order wins within the higher active level.
	// ************************************************************
	always_comb begin
		high_req    = request & level;
		found       = 1'b0;
		winner      = 4'h0;
		winner_high = 1'b0;
		for (int i = mivc_pkg::NUM_SLOTS - 1; i >= 0; i--) begin
			if (request[i] && !(|high_req)) begin // R18
				found  = 1'b1;
				winner = 4'(i);
			end
		end
		for (int i = mivc_pkg::NUM_SLOTS - 1; i >= 0; i--) begin
			if (high_req[i]) begin // R18
				found       = 1'b1;
				winner      = 4'(i);
				winner_high = 1'b1;
			end
		end
	end
endmodule : mivc_arbiter
`default_nettype wire

/* File: core/mivc_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
// How it works
// R01: Reset starts execution at vector zero.
// R02: External input zero, slot 0, hardware cleared.
// R03: Timer zero overflow, slot 1, hardware cleared.
// R04: External input one, slot 2, hardware cleared.
// R05: Timer one overflow, slot 3, hardware cleared.
// R06: UART receive or transmit, slot 4.
// R07: Timer two either overflow, slot 5.
// R08: Any of four SPI flags, slot 6.
// R09: SMBus flag, slot 7, extended bit 0.
// R10: Slots 8 and 13 never request.
// R11: ADC window compare, slot 9, extended bit 2.
// R12: ADC conversion done, slot 10, extended bit 3.
// R13: Counter array overflow or match, slot 11.
// R14: Comparator either edge, slot 12, extended bit 5.
// R15: Timer three either overflow, slot 14, bit 7.
// R16: Global gate low blocks every request.
// R17: Timer two masked unless its enable set.
// R18: Level first, then fixed order; high preempts low.
// R19: Flags set regardless; request needs flag, mask, gate.
// R20: Requests are decoded every clock cycle.
// R21: Vector and strobe held until core acknowledges.
module mivc_ctrl (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        ext_input0_flag,
	input  wire logic        timer0_ovf_flag,
	input  wire logic        ext_input1_flag,
	input  wire logic        timer1_ovf_flag,
	input  wire logic        uart_rx_flag,
	input  wire logic        uart_tx_flag,
	input  wire logic        timer2_high_ovf,
	input  wire logic        timer2_low_ovf,
	input  wire logic        spi_done_flag,
	input  wire logic        spi_write_collision,
	input  wire logic        spi_mode_fault,
	input  wire logic        spi_rx_overrun,
	input  wire logic        smbus_flag,
	input  wire logic        adc_window_flag,
	input  wire logic        adc_done_flag,
	input  wire logic        counter_array_ovf,
	input  wire logic [2:0]  counter_module_match,
	input  wire logic        comparator_fall_flag,
	input  wire logic        comparator_rise_flag,
	input  wire logic        timer3_high_ovf,
	input  wire logic        timer3_low_ovf,
	output logic             irq_req,
	output logic [15:0]      irq_vector,
	input  wire logic        irq_ack,
	input  wire logic        isr_return,
	output logic [3:0]       hw_clear
);
	logic [7:0]  primary_mask_reg;
	logic [7:0]  primary_level_reg;
	logic [7:0]  extended_mask_reg;
	logic [7:0]  extended_level_reg;
	logic [7:0]  next_primary_mask_reg;
	logic [7:0]  next_primary_level_reg;
	logic [7:0]  next_extended_mask_reg;
	logic [7:0]  next_extended_level_reg;
	logic [14:0] sw_flag;
	logic [14:0] next_sw_flag;
	logic        wr_pend;
	logic        rd_pend;
	logic [7:0]  addr_q;
	logic        next_wr_pend;
	logic        next_rd_pend;
	logic [7:0]  next_addr_q;
	logic [31:0] next_hrdata;
	logic [14:0] pending;
	logic [14:0] slot_mask;
	logic [14:0] slot_level;
	logic [14:0] request;
	logic        found;
	logic [3:0]  winner;
	logic        winner_high;
	logic        in_low;
	logic        in_high;
	logic        next_in_low;
	logic        next_in_high;
	logic [15:0] next_irq_vector;
	logic [3:0]  next_hw_clear;
	logic        eligible;
	logic [3:0]  offer_slot;
	logic [3:0]  next_offer_slot;
	logic        offer_high;
	logic        next_offer_high;

	typedef enum logic [1:0] {
		MIVC_IDLE = 2'b01,
		MIVC_CALL = 2'b10
	} mivc_state_t;
	mivc_state_t state;
	mivc_state_t next_state;

	function automatic logic [15:0] slot_vector(input logic [3:0] slot);
		slot_vector = mivc_pkg::VECTOR_BASE + 16'(slot) * mivc_pkg::VECTOR_STEP;
	endfunction : slot_vector

	// Both control pairs share one layout, so enables and levels map through one place.
	function automatic logic [14:0] slot_map(input logic [7:0] primary,
		input logic [7:0] extended);
		slot_map = {extended[7], 1'b0, extended[5:2], 1'b0, extended[0], primary[6:0]}; // R10
	endfunction : slot_map

	// ************************************************************
	// Pending flags and request gating.
	// ************************************************************
	always_comb begin
		pending[0]  = ext_input0_flag;                    // R02
		pending[1]  = timer0_ovf_flag;                    // R03
		pending[2]  = ext_input1_flag;                    // R04
		pending[3]  = timer1_ovf_flag;                    // R05
		pending[4]  = uart_rx_flag | uart_tx_flag;        // R06
		pending[5]  = timer2_high_ovf | timer2_low_ovf;   // R07
		pending[6]  = spi_done_flag | spi_write_collision
			| spi_mode_fault | spi_rx_overrun;            // R08
		pending[7]  = smbus_flag;                         // R09
		pending[8]  = 1'b0;                               // R10
		pending[9]  = adc_window_flag;                    // R11
		pending[10] = adc_done_flag;                      // R12
		pending[11] = counter_array_ovf | (|counter_module_match); // R13
		pending[12] = comparator_fall_flag | comparator_rise_flag; // R14
		pending[13] = 1'b0;                               // R10
		pending[14] = timer3_high_ovf | timer3_low_ovf;   // R15
		pending     = (pending | sw_flag) & ~mivc_pkg::RESERVED_SLOTS; // R19
		slot_mask   = slot_map(primary_mask_reg, extended_mask_reg); // R17
		slot_level  = slot_map(primary_level_reg, extended_level_reg); // R18
		request     = pending & slot_mask
			& {mivc_pkg::NUM_SLOTS{primary_mask_reg[mivc_pkg::GATE_BIT]}}; // R16 R19
	end

	mivc_arbiter u_arb (
		.request     (request),
		.level       (slot_level),
		.found       (found),
		.winner      (winner),
		.winner_high (winner_high)
	);

	// ************************************************************
	// Vectoring handshake with the core.
	// ************************************************************
	always_comb begin
		eligible        = found && !in_high && (!in_low || winner_high); // R18
		next_state      = state;
		next_irq_vector = irq_vector;
		next_offer_slot = offer_slot;
		next_offer_high = offer_high;
		next_hw_clear   = 4'h0;
		case (state)
			MIVC_IDLE: begin
				if (eligible) begin // R20
					next_state      = MIVC_CALL;
					next_irq_vector = slot_vector(winner); // R21
					next_offer_slot = winner;
					next_offer_high = winner_high; // R18
				end
			end
			MIVC_CALL: begin
				// The offered slot is kept, since the arbiter may move on before the answer.
				if (irq_ack) begin // R21
					next_state = MIVC_IDLE;
					if (mivc_pkg::HW_CLEAR_SLOTS[offer_slot]) begin
						next_hw_clear = 4'(1) << offer_slot; // R02 R03 R04 R05
					end
				end
			end
			default: begin
				next_state = MIVC_IDLE;
			end
		endcase
	end

	// Keeping the vector registered avoids a change under the core mid-call.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state      <= MIVC_IDLE;
			irq_vector <= mivc_pkg::RESET_VECTOR; // R01
			offer_slot <= 4'h0;
			offer_high <= 1'b0;
			hw_clear   <= 4'h0;
		end else begin
			state      <= next_state;
			irq_vector <= next_irq_vector;
			offer_slot <= next_offer_slot;
			offer_high <= next_offer_high;
			hw_clear   <= next_hw_clear;
		end
	end

	assign irq_req = (state == MIVC_CALL); // R21

	// ************************************************************
	// Service nesting, one level of each priority.
	// ************************************************************
	always_comb begin
		next_in_low  = in_low;
		next_in_high = in_high;
		if (isr_return) begin
			if (in_high) begin
				next_in_high = 1'b0;
			end else begin
				next_in_low = 1'b0;
			end
		end
		if (state == MIVC_CALL && irq_ack) begin // R18
			if (offer_high) begin
				next_in_high = 1'b1;
			end else begin
				next_in_low = 1'b1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			in_low  <= 1'b0;
			in_high <= 1'b0;
		end else begin
			in_low  <= next_in_low;
			in_high <= next_in_high;
		end
	end

	// ************************************************************
	// Register slave.
	// ************************************************************
	always_comb begin
		next_primary_mask_reg   = primary_mask_reg;
		next_primary_level_reg  = primary_level_reg;
		next_extended_mask_reg  = extended_mask_reg;
		next_extended_level_reg = extended_level_reg;
		next_sw_flag            = sw_flag;
		next_wr_pend            = 1'b0;
		next_rd_pend            = 1'b0;
		next_addr_q             = addr_q;
		next_hrdata             = hrdata;
		if (wr_pend) begin
			case (addr_q)
				mivc_pkg::ADDR_PRIMARY_MASK:  next_primary_mask_reg   = hwdata[7:0];
				mivc_pkg::ADDR_PRIMARY_LEVEL: next_primary_level_reg  = hwdata[7:0];
				mivc_pkg::ADDR_EXT_MASK:      next_extended_mask_reg  = hwdata[7:0];
				mivc_pkg::ADDR_EXT_LEVEL:     next_extended_level_reg = hwdata[7:0];
				mivc_pkg::ADDR_SW_SET:        next_sw_flag = sw_flag | hwdata[14:0];
				mivc_pkg::ADDR_SW_CLEAR:      next_sw_flag = sw_flag & ~hwdata[14:0];
				default: begin
				end
			endcase
		end
		// Software-set flags of hardware-cleared slots drop on vectoring.
		next_sw_flag = next_sw_flag & ~{11'h0, next_hw_clear};
		// Read data come from the next values, so a read right behind a write sees it.
		if (hsel && hready && htrans == mivc_pkg::HTRANS_NONSEQ) begin
			next_wr_pend = hwrite;
			next_rd_pend = !hwrite;
			next_addr_q  = haddr[7:0];
			case (haddr[7:0])
				mivc_pkg::ADDR_PRIMARY_MASK:  next_hrdata = {24'h0, next_primary_mask_reg};
				mivc_pkg::ADDR_PRIMARY_LEVEL:
					next_hrdata = {24'h0, next_primary_level_reg | mivc_pkg::PRIMARY_LEVEL_RO};
				mivc_pkg::ADDR_EXT_MASK:      next_hrdata = {24'h0, next_extended_mask_reg};
				mivc_pkg::ADDR_EXT_LEVEL:     next_hrdata = {24'h0, next_extended_level_reg};
				mivc_pkg::ADDR_STATUS:
					next_hrdata = {8'h0, irq_vector, 3'h0, irq_req, in_high, in_low, 2'h0};
				mivc_pkg::ADDR_PENDING:       next_hrdata = {17'h0, pending};
				mivc_pkg::ADDR_SW_SET:        next_hrdata = {17'h0, next_sw_flag};
				default:                      next_hrdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			primary_mask_reg   <= mivc_pkg::RESET_MASK;
			primary_level_reg  <= mivc_pkg::RESET_LEVEL;
			extended_mask_reg  <= mivc_pkg::RESET_MASK;
			extended_level_reg <= mivc_pkg::RESET_LEVEL;
			sw_flag            <= 15'h0;
			wr_pend            <= 1'b0;
			rd_pend            <= 1'b0;
			addr_q             <= 8'h0;
			hrdata             <= 32'h0;
		end else begin
			primary_mask_reg   <= next_primary_mask_reg;
			primary_level_reg  <= next_primary_level_reg;
			extended_mask_reg  <= next_extended_mask_reg;
			extended_level_reg <= next_extended_level_reg;
			sw_flag            <= next_sw_flag;
			wr_pend            <= next_wr_pend;
			rd_pend            <= next_rd_pend;
			addr_q             <= next_addr_q;
			hrdata             <= next_hrdata;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
endmodule : mivc_ctrl
`default_nettype wire

/* File: core/mivc_pkg.sv */
package mivc_pkg;

	// ************************************************************
	// Register map, word aligned, byte addresses.
	// ************************************************************
	localparam logic [7:0] ADDR_PRIMARY_MASK  = 8'ha8;
	localparam logic [7:0] ADDR_PRIMARY_LEVEL = 8'hb8;
	localparam logic [7:0] ADDR_EXT_MASK      = 8'he4;
	localparam logic [7:0] ADDR_EXT_LEVEL     = 8'hf4;
	localparam logic [7:0] ADDR_STATUS        = 8'hc0;
	localparam logic [7:0] ADDR_PENDING       = 8'hc4;
	localparam logic [7:0] ADDR_SW_SET        = 8'hc8;
	localparam logic [7:0] ADDR_SW_CLEAR      = 8'hcc;

	// ************************************************************
	// Field positions and reset values.
	// ************************************************************
	localparam int        GATE_BIT          = 7;
	localparam int        NUM_SLOTS         = 15;
	localparam logic [7:0] RESET_MASK       = 8'h00;
	localparam logic [7:0] RESET_LEVEL      = 8'h00;
	localparam logic [7:0] PRIMARY_LEVEL_RO = 8'h80;
	localparam logic [1:0] HTRANS_NONSEQ    = 2'h2;
	localparam logic [15:0] RESET_VECTOR    = 16'h0000;
	localparam logic [15:0] VECTOR_BASE     = 16'h0003;
	localparam logic [15:0] VECTOR_STEP     = 16'h0008;

	// ************************************************************
	// Slot order, with two reserved slots.
	// ************************************************************
	localparam logic [14:0] RESERVED_SLOTS = 15'h2100;
	localparam logic [14:0] HW_CLEAR_SLOTS = 15'h000f;

	// Number of slots whose control bits sit in the primary register; slots 7 and up use the extended one.
	localparam int SLOT_IN_PRIMARY = 7;

endpackage : mivc_pkg

/* File: testbench/mivc_core_model.sv */
`timescale 1ns/10ps
`default_nettype none
module mivc_core_model (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       irq_req,
	input  wire logic [3:0] delay,
	output logic            irq_ack
);
	// ************************************************************
	// Core answer, prompt or slow as delay asks.
	// ************************************************************
	logic [3:0] wait_count;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wait_count <= 4'h0;
			irq_ack    <= 1'b0;
		end else begin
			irq_ack    <= irq_req && !irq_ack && wait_count >= delay;
			wait_count <= (irq_req && !irq_ack) ? wait_count + 4'h1 : 4'h0;
		end
	end
endmodule : mivc_core_model
`default_nettype wire

/* File: testbench/mivc_ctrl_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module mivc_ctrl_checker (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        irq_req,
	input wire logic [15:0] irq_vector,
	input wire logic        irq_ack,
	input wire logic [3:0]  hw_clear
);
	// ************************************************************
	// Vector offer and hardware clear.
	// ************************************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_offer;
		irq_req && !irq_ack;
	endsequence
	sequence s_taken;
		irq_req && irq_ack;
	endsequence
	a_reset_vector: assert property ($rose(hresetn) |-> !irq_req && irq_vector == 16'h0000)
		else $error("vector not zero after reset");
	a_vector_hold: assert property (s_offer |=> irq_req && $stable(irq_vector))
		else $error("offer changed before ack");
	a_ack_drop: assert property (s_taken |=> !irq_req)
		else $error("request stayed up after ack");
	a_hw_clear_slot: assert property (s_taken ##0 (irq_vector < 16'h0020)
		|=> hw_clear == 4'h1 << $past(irq_vector[4:3]))
		else $error("wrong hardware clear");
	a_no_hw_clear: assert property (s_taken ##0 (irq_vector > 16'h001b) |=> hw_clear == 4'h0)
		else $error("clear for a software cleared source");
	a_clear_cause: assert property (hw_clear != 4'h0 |-> $past(irq_ack) && $past(irq_req))
		else $error("clear without vectoring");
	a_clear_pulse: assert property (hw_clear != 4'h0 |=> hw_clear == 4'h0)
		else $error("clear longer than one cycle");
	a_slot_valid: assert property (irq_req |-> irq_vector[2:0] == 3'h3 && irq_vector <= 16'h0073
		&& irq_vector != 16'h0043 && irq_vector != 16'h006b)
		else $error("vector outside the slot table");
endmodule : mivc_ctrl_checker
bind mivc_ctrl mivc_ctrl_checker u_chk (.hclk(hclk), .hresetn(hresetn), .irq_req(irq_req),
	.irq_vector(irq_vector), .irq_ack(irq_ack), .hw_clear(hw_clear));
`default_nettype wire

/* File: testbench/test_mcu_interrupt_vectoring.sv */
`timescale 1ns/10ps
`default_nettype none
module test_mcu_interrupt_vectoring;
	// ************************************************************
	// Bench signals and source slot table.
	// ************************************************************
	logic        hclk       = 1'b0;
	logic        hresetn    = 1'b0;
	logic        hsel       = 1'b0;
	logic [31:0] haddr      = 32'h0;
	logic [1:0]  htrans     = 2'h0;
	logic        hwrite     = 1'b0;
	logic [31:0] hwdata     = 32'h0;
	logic [22:0] src        = 23'h0;
	logic        isr_return = 1'b0;
	logic [3:0]  delay      = 4'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        irq_req;
	logic        irq_ack;
	logic [15:0] irq_vector;
	logic [3:0]  hw_clear;
	int          fail_count  = 0;
	int          comparisons = 0;
	localparam int SLOT [23] = '{0,1,2,3,4,4,5,5,6,6,6,6,7,9,10,11,11,11,11,12,12,14,14};
	mivc_ctrl uut (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.ext_input0_flag(src[0]), .timer0_ovf_flag(src[1]), .ext_input1_flag(src[2]),
		.timer1_ovf_flag(src[3]), .uart_rx_flag(src[4]), .uart_tx_flag(src[5]),
		.timer2_high_ovf(src[6]), .timer2_low_ovf(src[7]), .spi_done_flag(src[8]),
		.spi_write_collision(src[9]), .spi_mode_fault(src[10]), .spi_rx_overrun(src[11]),
		.smbus_flag(src[12]), .adc_window_flag(src[13]), .adc_done_flag(src[14]),
		.counter_array_ovf(src[15]), .counter_module_match(src[18:16]),
		.comparator_fall_flag(src[19]), .comparator_rise_flag(src[20]),
		.timer3_high_ovf(src[21]), .timer3_low_ovf(src[22]),
		.irq_req, .irq_vector, .irq_ack, .isr_return, .hw_clear
	);
	mivc_core_model core (.hclk, .hresetn, .irq_req, .delay, .irq_ack);
	initial forever #20 hclk = ~hclk;
	task automatic test_done;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : test_done
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			fail_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : check
	task automatic ready_edge;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 64);
		if (n >= 64) begin
			fail_count++;
			test_done();
		end
	endtask : ready_edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		ready_edge();
		htrans <= 2'h0;
		hwdata <= d;
		ready_edge();
		q = hrdata;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		check(q | {hresp, 31'h0}, e);
	endtask : rd
	task automatic set_ctl(input logic g, input logic [14:0] en, input logic [14:0] lv);
		wr(8'ha8, {24'h0, g, en[6:0]});
		wr(8'he4, {24'h0, en[14:7]});
		wr(8'hb8, {25'h0, lv[6:0]});
		wr(8'hf4, {24'h0, lv[14:7]});
	endtask : set_ctl
	// Off requests are watched for three cycles, past the one cycle of detection.
	task automatic expect_irq(input logic on, input int s);
		int n;
		n = 0;
		while ((on ? irq_req !== 1'b1 : 1'b1) && n < 3) begin
			@(posedge hclk);
			n++;
		end
		check({31'h0, irq_req}, {31'h0, on});
		if (on) check({16'h0, irq_vector}, 32'h3 + 32'(8 * s));
	endtask : expect_irq
	task automatic serve(input int s);
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (irq_req !== 1'b0 && n < 40);
		check({31'h0, irq_req}, 32'h0);
		check({28'h0, hw_clear}, (s < 4) ? 32'h1 << s : 32'h0);
		src <= 23'h0;
	endtask : serve
	task automatic ret;
		isr_return <= 1'b1;
		@(posedge hclk);
		isr_return <= 1'b0;
		@(posedge hclk);
	endtask : ret
	function automatic int win(input int x, input int y, input logic [14:0] lv);
		return (lv[x] != lv[y]) ? (lv[x] ? x : y) : (x < y ? x : y);
	endfunction : win
	initial begin
		logic [31:0] q;
		logic [14:0] lv;
		int          a;
		int          b;
		q = $urandom(2172);
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(8'ha8, 32'h0);
		rd(8'hb8, 32'h80);
		rd(8'h10, 32'h0);
		q = $urandom & 32'h7f;
		wr(8'ha8, q);
		rd(8'ha8, q);
		set_ctl(1'b0, 15'h7fff, 15'h0);
		src <= '1;
		expect_irq(1'b0, 0);
		src <= 23'h0;
		for (int i = 0; i < 23; i++) begin
			delay <= 4'($urandom);
			set_ctl(1'b1, ~(15'h1 << SLOT[i]), 15'h0);
			src <= 23'h1 << i;
			expect_irq(1'b0, 0);
			rd(8'hc4, 32'h1 << SLOT[i]);
			// The gate opens last, so the core cannot answer while masks are still written.
			set_ctl(1'b0, 15'h7fff, 15'h0);
			wr(8'ha8, 32'hff);
			expect_irq(1'b1, SLOT[i]);
			serve(SLOT[i]);
			ret();
		end
		for (int k = 0; k < 24; k++) begin
			a = $urandom % 23;
			b = $urandom % 23;
			lv = 15'($urandom);
			set_ctl(1'b1, 15'h7fff, lv);
			src <= (23'h1 << a) | (23'h1 << b);
			expect_irq(1'b1, win(SLOT[a], SLOT[b], lv));
			serve(win(SLOT[a], SLOT[b], lv));
			ret();
		end
		set_ctl(1'b1, 15'h7fff, 15'h4002);
		src <= 23'h1;
		expect_irq(1'b1, 0);
		serve(0);
		@(posedge hclk);
		src <= 23'h10;
		expect_irq(1'b0, 0);
		src <= 23'h12;
		expect_irq(1'b1, 1);
		serve(1);
		@(posedge hclk);
		src <= 23'h1 << 21;
		expect_irq(1'b0, 0);
		ret();
		expect_irq(1'b1, 14);
		serve(14);
		ret();
		ret();
		delay <= 4'hf;
		wr(8'hc8, 32'h8);
		expect_irq(1'b1, 3);
		rd(8'hc0, 32'h1b10);
		serve(3);
		rd(8'hc8, 32'h0);
		ret();
		wr(8'ha8, 32'h7f);
		wr(8'hc8, 32'h10);
		rd(8'hc8, 32'h10);
		wr(8'hcc, 32'h10);
		rd(8'hc8, 32'h0);
		test_done();
	end
endmodule : test_mcu_interrupt_vectoring
`default_nettype wire
